// >>> rtl/uefc_cfg.svh
// constants of the enhanced flow-control block: offsets, fields, resets, sizes
// assumes one 8-bit register per aligned 32-bit Wishbone word
`ifndef UEFC_CFG_SVH
`define UEFC_CFG_SVH
`define UEFC_ADR_W 6
`define UEFC_OFS_FEAT 6'h00
`define UEFC_OFS_EFC 6'h04
`define UEFC_OFS_TXLVL 6'h08
`define UEFC_OFS_TX_FIFO_TRIGGER 6'h0C
`define UEFC_OFS_RXLVL 6'h10
`define UEFC_OFS_RXTRG 6'h14
`define UEFC_OFS_IEN 6'h18
`define UEFC_OFS_FCTL 6'h1C
`define UEFC_OFS_MCTL 6'h20
`define UEFC_OFS_DLY 6'h24
`define UEFC_OFS_ON1 6'h28
`define UEFC_OFS_ON2 6'h2C
`define UEFC_OFS_OFF1 6'h30
`define UEFC_OFS_OFF2 6'h34
`define UEFC_OFS_ISTS 6'h38
`define UEFC_RST_8 8'h00
`define UEFC_FEAT_IRINV 4
`define UEFC_FEAT_RS485 5
`define UEFC_EFC_ENH 4
`define UEFC_EFC_SPEC 5
`define UEFC_EFC_AUTOOUT 6
`define UEFC_EFC_AUTOIN 7
`define UEFC_MCTL_DTR 0
`define UEFC_MCTL_RTS 1
`define UEFC_MCTL_SEL 2
`define UEFC_ISTS_CHAR 4
`define UEFC_ISTS_FLOW 5
`define UEFC_IEN_GATE 8'hF0
`define UEFC_ISTS_GATE 8'h30
`define UEFC_FCTL_GATE 8'h30
`define UEFC_MCTL_GATE 8'hE0
`define UEFC_TABLE_D 2'h3
`define UEFC_FIFO_DEPTH 8'h40
`endif

// >>> rtl/uefc_pkg.sv
// types of the enhanced flow-control block
// assumes uefc_cfg.svh supplies the numeric constants
package uefc_pkg;
    typedef enum logic [1:0] {
        UEFC_FC_IDLE = 2'b00,
        UEFC_FC_FIRST = 2'b01,
        UEFC_FC_SECOND = 2'b10
    } uefc_fc_state_e;
    typedef struct packed {
        logic tx_a;
        logic tx_b;
        logic rx_a;
        logic rx_b;
        logic rx_any;
        logic rx_seq;
    } uefc_flow_sel_s;
endpackage

// >>> rtl/uefc_core.sv
// one channel of enhanced uart flow control, registers on classic wishbone
// assumes the shifter, receiver and fifo storage sit outside and report events
`timescale 1ns/10ps
`include "uefc_cfg.svh"
`default_nettype none
module uefc_core
    import uefc_pkg::*;
#(
    parameter int DEPTH = 64
) (
    input wire logic CLK_I,
    input wire logic RST_B_I,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] ADR_I,
    input wire logic [31:0] DAT_I,
    output logic [31:0] DAT_O,
    output logic ACK_O,
    input wire logic TX_PUSH_I,
    input wire logic TX_POP_I,
    input wire logic TX_SHIFT_BUSY_I,
    input wire logic BIT_TICK_I,
    input wire logic RX_CHAR_VALID_I,
    input wire logic [7:0] RX_CHAR_I,
    input wire logic RX_POP_I,
    input wire logic [7:0] RX_TRIG_UP_I,
    input wire logic [7:0] RX_TRIG_DN_I,
    input wire logic IR_RX_I,
    input wire logic CTS_N_I,
    input wire logic DSR_N_I,
    input wire logic FLOW_REQ_I,
    input wire logic FLOW_OFF_I,
    input wire logic FC_READY_I,
    output logic FC_VALID_O,
    output logic [7:0] FC_CHAR_O,
    output logic RX_PUSH_O,
    output logic [7:0] RX_DATA_O,
    output logic IR_RX_O,
    output logic RTS_N_O,
    output logic DTR_N_O,
    output logic TX_INT_O,
    output logic TX_TRIG_INT_O,
    output logic RX_TRIG_INT_O,
    output logic TX_HALT_O,
    output logic [7:0] IEN_O,
    output logic [7:0] FCTL_O
);
    logic [7:0] feat_reg, efc_reg, tx_fifo_trigger_reg, rxtrg_reg, ien_reg, fctl_reg, mctl_reg;
    logic [7:0] dly_reg, on1_reg, on2_reg, off1_reg, off2_reg, ists_reg;
    logic [7:0] txlvl_reg, rxlvl_reg, dat_reg, cnt_reg, hyst;
    logic [8:0] up_lvl, dn_lvl;
    logic ack_reg, wr, flow_stop_reg, paused_reg, dir_reg, push_rx;
    logic on_pend_reg, off_pend_reg, got_on, got_off, spec_hit, store;
    logic [5:0] adr;
    uefc_fc_state_e fc_reg;
    uefc_flow_sel_s fs;

    ////////////////////////////////////////////////////////////////////////
    // wishbone slave: one wait state, unmapped reads return zero
    // the write commits on the edge that carries ack, so an aborted cycle writes nothing
    assign adr = ADR_I[5:0];
    assign wr = CYC_I && STB_I && WE_I && ack_reg && SEL_I[0];

    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= CYC_I && STB_I && !ack_reg;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            dat_reg <= `UEFC_RST_8;
        end else begin
            case (adr)
                `UEFC_OFS_FEAT: dat_reg <= feat_reg;
                `UEFC_OFS_EFC: dat_reg <= efc_reg;
                `UEFC_OFS_TXLVL: dat_reg <= txlvl_reg;
                `UEFC_OFS_RXLVL: dat_reg <= rxlvl_reg;
                `UEFC_OFS_IEN: dat_reg <= ien_reg;
                `UEFC_OFS_FCTL: dat_reg <= fctl_reg;
                `UEFC_OFS_MCTL: dat_reg <= mctl_reg;
                `UEFC_OFS_ON1: dat_reg <= on1_reg;
                `UEFC_OFS_ON2: dat_reg <= on2_reg;
                `UEFC_OFS_OFF1: dat_reg <= off1_reg;
                `UEFC_OFS_OFF2: dat_reg <= off2_reg;
                `UEFC_OFS_ISTS: dat_reg <= ists_reg;
                default: dat_reg <= `UEFC_RST_8;
            endcase
        end
    end
    assign ACK_O = ack_reg;
    assign DAT_O = {24'h000000, dat_reg};

    ////////////////////////////////////////////////////////////////////////
    // plain registers; trigger and delay registers are write-only
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            feat_reg <= `UEFC_RST_8;
            efc_reg <= `UEFC_RST_8;
            tx_fifo_trigger_reg <= `UEFC_RST_8;
            rxtrg_reg <= `UEFC_RST_8;
            dly_reg <= `UEFC_RST_8;
            on1_reg <= `UEFC_RST_8;
            on2_reg <= `UEFC_RST_8;
            off1_reg <= `UEFC_RST_8;
            off2_reg <= `UEFC_RST_8;
        end else if (wr) begin
            case (adr)
                `UEFC_OFS_FEAT: feat_reg <= DAT_I[7:0];
                `UEFC_OFS_EFC: efc_reg <= DAT_I[7:0];
                `UEFC_OFS_TX_FIFO_TRIGGER: tx_fifo_trigger_reg <= DAT_I[7:0];
                `UEFC_OFS_RXTRG: rxtrg_reg <= DAT_I[7:0];
                `UEFC_OFS_DLY: dly_reg <= DAT_I[7:0];
                `UEFC_OFS_ON1: on1_reg <= DAT_I[7:0];
                `UEFC_OFS_ON2: on2_reg <= DAT_I[7:0];
                `UEFC_OFS_OFF1: off1_reg <= DAT_I[7:0];
                `UEFC_OFS_OFF2: off2_reg <= DAT_I[7:0];
                default: ;
            endcase
        end
    end

    // legacy software cannot touch the enhanced bits while the enhance bit is low
    function automatic logic [7:0] gated(input logic [7:0] old, input logic [7:0] nw,
                                         input logic [7:0] msk, input logic en);
        gated = en ? nw : ((nw & ~msk) | (old & msk));
    endfunction

    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            ien_reg <= `UEFC_RST_8;
            fctl_reg <= `UEFC_RST_8;
            mctl_reg <= `UEFC_RST_8;
        end else if (wr) begin
            if (adr == `UEFC_OFS_IEN) begin
                ien_reg <= gated(ien_reg, DAT_I[7:0], `UEFC_IEN_GATE, efc_reg[`UEFC_EFC_ENH]);
            end
            if (adr == `UEFC_OFS_FCTL) begin
                fctl_reg <= gated(fctl_reg, DAT_I[7:0], `UEFC_FCTL_GATE, efc_reg[`UEFC_EFC_ENH]);
            end
            if (adr == `UEFC_OFS_MCTL) begin
                mctl_reg <= gated(mctl_reg, DAT_I[7:0], `UEFC_MCTL_GATE, efc_reg[`UEFC_EFC_ENH]);
            end
        end
    end

    // status bits: hardware set wins over a software write in the same cycle
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            ists_reg <= `UEFC_RST_8;
        end else begin
            if (wr && adr == `UEFC_OFS_ISTS && efc_reg[`UEFC_EFC_ENH]) begin
                ists_reg <= DAT_I[7:0] & `UEFC_ISTS_GATE;
            end
            if (spec_hit || got_off) begin
                ists_reg[`UEFC_ISTS_CHAR] <= 1'b1;
            end
            if (flow_stop_reg != flow_stop_next()) begin
                ists_reg[`UEFC_ISTS_FLOW] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // fifo level counters, clamped at the fifo depth
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            txlvl_reg <= `UEFC_RST_8;
            rxlvl_reg <= `UEFC_RST_8;
        end else begin
            if (TX_PUSH_I && !TX_POP_I && txlvl_reg < 8'(DEPTH)) begin
                txlvl_reg <= txlvl_reg + 8'h01;
            end else if (TX_POP_I && !TX_PUSH_I && txlvl_reg != 8'h00) begin
                txlvl_reg <= txlvl_reg - 8'h01;
            end
            if (push_rx && !RX_POP_I && rxlvl_reg < 8'(DEPTH)) begin
                rxlvl_reg <= rxlvl_reg + 8'h01;
            end else if (RX_POP_I && !push_rx && rxlvl_reg != 8'h00) begin
                rxlvl_reg <= rxlvl_reg - 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // hardware output flow control with table-dependent hysteresis
    always_comb begin
        case (feat_reg[3:0])
            4'h1: hyst = 8'h04;
            4'h2: hyst = 8'h06;
            4'h3: hyst = 8'h08;
            4'h4: hyst = 8'h08;
            4'h5: hyst = 8'h10;
            4'h6: hyst = 8'h18;
            4'h7: hyst = 8'h20;
            4'h8: hyst = 8'h0C;
            4'h9: hyst = 8'h14;
            4'hA: hyst = 8'h1C;
            4'hB: hyst = 8'h24;
            4'hC: hyst = 8'h28;
            4'hD: hyst = 8'h2C;
            4'hE: hyst = 8'h30;
            4'hF: hyst = 8'h34;
            default: hyst = 8'h00;
        endcase
    end

    // next-level thresholds come from the trigger table logic outside, except in table D with nonzero hysteresis: rxtrg_reg plus and minus hyst
    always_comb begin
        if (feat_reg[7:6] == `UEFC_TABLE_D && hyst != 8'h00) begin
            up_lvl = {1'b0, rxtrg_reg} + {1'b0, hyst};
            dn_lvl = {1'b0, rxtrg_reg} - {1'b0, hyst};
        end else begin
            up_lvl = {1'b0, RX_TRIG_UP_I};
            dn_lvl = {1'b0, RX_TRIG_DN_I};
        end
    end

    function automatic logic flow_stop_next();
        if (!efc_reg[`UEFC_EFC_AUTOOUT]) begin
            flow_stop_next = 1'b0;
        end else if ({1'b0, rxlvl_reg} >= up_lvl) begin
            flow_stop_next = 1'b1;
        end else if ({1'b0, rxlvl_reg} < dn_lvl || dn_lvl[8]) begin
            flow_stop_next = dn_lvl[8] ? (rxlvl_reg == 8'h00 ? 1'b0 : flow_stop_reg) : 1'b0;
        end else begin
            flow_stop_next = flow_stop_reg;
        end
    endfunction

    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            flow_stop_reg <= 1'b0;
        end else begin
            flow_stop_reg <= flow_stop_next();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // rs485 direction with turn-around delay counted in bit times
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            dir_reg <= 1'b0;
            cnt_reg <= `UEFC_RST_8;
        end else if (!feat_reg[`UEFC_FEAT_RS485]) begin
            dir_reg <= 1'b0;
            cnt_reg <= `UEFC_RST_8;
        end else if (TX_PUSH_I || TX_SHIFT_BUSY_I || txlvl_reg != 8'h00) begin
            dir_reg <= 1'b1;
            cnt_reg <= {4'h0, dly_reg[7:4]};
        end else if (cnt_reg == 8'h00) begin
            dir_reg <= 1'b0;
        end else if (BIT_TICK_I) begin
            cnt_reg <= cnt_reg - 8'h01;
        end
    end

    // the pin is active low: high means the stop or transmit direction
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            RTS_N_O <= 1'b1;
            DTR_N_O <= 1'b1;
        end else begin
            if (feat_reg[`UEFC_FEAT_RS485]) begin
                RTS_N_O <= dir_reg;
            end else begin
                RTS_N_O <= !mctl_reg[`UEFC_MCTL_RTS] || (!mctl_reg[`UEFC_MCTL_SEL] && flow_stop_reg);
            end
            DTR_N_O <= !mctl_reg[`UEFC_MCTL_DTR] || (mctl_reg[`UEFC_MCTL_SEL] && flow_stop_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // software flow control decode
    always_comb begin
        fs.tx_a = efc_reg[3];
        fs.tx_b = efc_reg[2];
        fs.rx_a = efc_reg[1];
        fs.rx_b = efc_reg[0];
        fs.rx_any = efc_reg[1] && efc_reg[0] && (efc_reg[3] != efc_reg[2]);
        fs.rx_seq = efc_reg[1] && efc_reg[0] && (efc_reg[3] == efc_reg[2]);
    end

    // matching; in sequence mode the first half stays pending only until the next received character, which must be the second
    always_comb begin
        got_on = 1'b0;
        got_off = 1'b0;
        if (RX_CHAR_VALID_I) begin
            if (fs.rx_seq) begin
                got_on = on_pend_reg && RX_CHAR_I == on2_reg;
                got_off = off_pend_reg && RX_CHAR_I == off2_reg;
            end else begin
                got_on = (fs.rx_a && RX_CHAR_I == on1_reg) || (fs.rx_b && RX_CHAR_I == on2_reg);
                got_off = (fs.rx_a && RX_CHAR_I == off1_reg) || (fs.rx_b && RX_CHAR_I == off2_reg);
            end
        end
        spec_hit = RX_CHAR_VALID_I && efc_reg[`UEFC_EFC_SPEC] && RX_CHAR_I == off2_reg;
        // flow characters are consumed; a special match is kept unless it is a pause char
        store = RX_CHAR_VALID_I && !got_on && !got_off
              && !(fs.rx_seq && ((RX_CHAR_I == on1_reg) || (RX_CHAR_I == off1_reg)));
        push_rx = store;
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            on_pend_reg <= 1'b0;
            off_pend_reg <= 1'b0;
            paused_reg <= 1'b0;
        end else begin
            if (RX_CHAR_VALID_I) begin
                on_pend_reg <= fs.rx_seq && RX_CHAR_I == on1_reg;
                off_pend_reg <= fs.rx_seq && RX_CHAR_I == off1_reg;
            end
            if (got_off) begin
                paused_reg <= 1'b1;
            end else if (got_on || efc_reg[1:0] == 2'b00) begin
                paused_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            RX_PUSH_O <= 1'b0;
            RX_DATA_O <= `UEFC_RST_8;
        end else begin
            RX_PUSH_O <= push_rx;
            RX_DATA_O <= RX_CHAR_I;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transmit of pause/resume characters, one or two in a row
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            fc_reg <= UEFC_FC_IDLE;
            FC_VALID_O <= 1'b0;
            FC_CHAR_O <= `UEFC_RST_8;
        end else begin
            case (fc_reg)
                UEFC_FC_IDLE: begin
                    if (FLOW_REQ_I && (fs.tx_a || fs.tx_b)) begin
                        FC_VALID_O <= 1'b1;
                        if (fs.tx_a) begin
                            FC_CHAR_O <= FLOW_OFF_I ? off1_reg : on1_reg;
                            fc_reg <= fs.tx_b ? UEFC_FC_FIRST : UEFC_FC_SECOND;
                        end else begin
                            FC_CHAR_O <= FLOW_OFF_I ? off2_reg : on2_reg;
                            fc_reg <= UEFC_FC_SECOND;
                        end
                    end
                end
                UEFC_FC_FIRST: begin
                    if (FC_READY_I) begin
                        FC_CHAR_O <= (FC_CHAR_O == off1_reg) ? off2_reg : on2_reg;
                        fc_reg <= UEFC_FC_SECOND;
                    end
                end
                UEFC_FC_SECOND: begin
                    if (FC_READY_I) begin
                        FC_VALID_O <= 1'b0;
                        fc_reg <= UEFC_FC_IDLE;
                    end
                end
                default: fc_reg <= UEFC_FC_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupts, halt and infrared polarity
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            TX_INT_O <= 1'b0;
            TX_TRIG_INT_O <= 1'b0;
            RX_TRIG_INT_O <= 1'b0;
            TX_HALT_O <= 1'b0;
            IR_RX_O <= 1'b0;
        end else begin
            if (feat_reg[`UEFC_FEAT_RS485]) begin
                TX_INT_O <= txlvl_reg == 8'h00 && !TX_SHIFT_BUSY_I;
            end else begin
                TX_INT_O <= txlvl_reg == 8'h00;
            end
            TX_TRIG_INT_O <= txlvl_reg < tx_fifo_trigger_reg;
            RX_TRIG_INT_O <= rxlvl_reg >= rxtrg_reg && efc_reg[`UEFC_EFC_AUTOOUT];
            TX_HALT_O <= paused_reg || (efc_reg[`UEFC_EFC_AUTOIN]
                         && (mctl_reg[`UEFC_MCTL_SEL] ? DSR_N_I : CTS_N_I));
            IR_RX_O <= IR_RX_I ^ feat_reg[`UEFC_FEAT_IRINV];
        end
    end
    assign IEN_O = ien_reg;
    assign FCTL_O = fctl_reg;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);
    a_ir_polarity: assert property (##1 IR_RX_O == ($past(IR_RX_I) ^ $past(feat_reg[4])))
        else $error("infrared polarity wrong");
    a_tx_int_plain: assert property (!feat_reg[5] && txlvl_reg == 8'h00 |=> TX_INT_O)
        else $error("holding empty interrupt missing");
    a_rs485_rise: assert property (feat_reg[5] && TX_PUSH_I |=> ##1 !RTS_N_O == 1'b0)
        else $error("direction not raised on load");
    a_tx_int_shift: assert property (feat_reg[5] && TX_SHIFT_BUSY_I |=> !TX_INT_O)
        else $error("interrupt before shifter empty");
    a_enh_gate: assert property (wr && adr == `UEFC_OFS_IEN && !efc_reg[4] |=> ien_reg[7:4] == $past(ien_reg[7:4]))
        else $error("gated bits changed");
    a_halt_cts: assert property (efc_reg[7] && !mctl_reg[2] && CTS_N_I && $stable(efc_reg) |=> TX_HALT_O)
        else $error("transmit not halted");
    a_tx_trig: assert property (txlvl_reg < tx_fifo_trigger_reg |=> TX_TRIG_INT_O)
        else $error("transmit trigger interrupt missing");
    a_lvl_track: assert property (TX_PUSH_I && !TX_POP_I && txlvl_reg < 8'h40 |=> txlvl_reg == $past(txlvl_reg) + 8'h01)
        else $error("level counter lagged");
    a_rx_bound: assert property (rxlvl_reg <= `UEFC_FIFO_DEPTH)
        else $error("receive level over depth");
    a_spec_flag: assert property (spec_hit |=> ists_reg[4])
        else $error("special flag not set");
    c_dual_send: cover property (fc_reg == UEFC_FC_FIRST ##[1:20] fc_reg == UEFC_FC_SECOND);
    c_flow_stop: cover property ($rose(flow_stop_reg));
    c_rs485_fall: cover property ($rose(RTS_N_O) ##[1:200] $fell(RTS_N_O));
endmodule
`default_nettype wire

// >>> bench/uefc_remote.sv
// remote station model: takes flow characters, drives the clear-to-send line
// assumes the bench commands a stop on the clear-to-send line
`timescale 1ns/10ps
`default_nettype none
module uefc_remote (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic fc_valid_i,
    input wire logic [7:0] fc_char_i,
    input wire logic stop_i,
    output logic fc_ready_o,
    output logic cts_n_o,
    output logic [7:0] got0_o,
    output logic [7:0] got1_o
);
////////////////////////////////////////////////////////////////
// every other cycle only, so a device that ignores ready is caught
always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
        fc_ready_o <= 1'b0;
        got0_o <= 8'h00;
        got1_o <= 8'h00;
    end else begin
        fc_ready_o <= fc_valid_i & ~fc_ready_o;
        if (fc_valid_i && fc_ready_o) begin
            got0_o <= got1_o;
            got1_o <= fc_char_i;
        end
    end
end
assign cts_n_o = stop_i;
endmodule
`default_nettype wire

// >>> bench/test_uart_enhanced_flow_control.sv
// bench of the enhanced flow-control channel, wishbone master and remote model
// assumes the core answers every request within a few cycles
`timescale 1ns/10ps
`include "uefc_cfg.svh"
`default_nettype none
module test_uart_enhanced_flow_control;
logic clk = 1'b0, rst_b = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, fcv, fifo_control, cts, stop = 1'b0;
logic [31:0] adr = 32'h0, dat = 32'h0, dato;
logic push = 1'b0, ir = 1'b0, txint, tti, rti, halt, irout, rts, dtr, rxp;
logic [7:0] fcc, ien, fctl, rxd, g0, g1, q;
logic pop = 1'b0, busy = 1'b0, tick = 1'b0, rxv = 1'b0, rxpop = 1'b0;
logic [7:0] rxc = 8'h00;
int n_mismatch = 0, n_checks = 0, cyc_cnt = 0;
initial forever #20 clk = ~clk;
uefc_core uut (.CLK_I(clk), .RST_B_I(rst_b), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .SEL_I(4'hF),
    .ADR_I(adr), .DAT_I(dat), .DAT_O(dato), .ACK_O(ack), .TX_PUSH_I(push), .TX_POP_I(pop),
    .TX_SHIFT_BUSY_I(busy), .BIT_TICK_I(tick), .RX_CHAR_VALID_I(rxv), .RX_CHAR_I(rxc),
    .RX_POP_I(rxpop), .RX_TRIG_UP_I(8'h00), .RX_TRIG_DN_I(8'h00), .IR_RX_I(ir), .CTS_N_I(cts),
    .DSR_N_I(1'b1), .FLOW_REQ_I(push), .FLOW_OFF_I(1'b1), .FC_READY_I(fifo_control), .FC_VALID_O(fcv),
    .FC_CHAR_O(fcc), .RX_PUSH_O(rxp), .RX_DATA_O(rxd), .IR_RX_O(irout), .RTS_N_O(rts),
    .DTR_N_O(dtr), .TX_INT_O(txint), .TX_TRIG_INT_O(tti), .RX_TRIG_INT_O(rti), .TX_HALT_O(halt),
    .IEN_O(ien), .FCTL_O(fctl));
uefc_remote far (.clk_i(clk), .rst_b_i(rst_b), .fc_valid_i(fcv), .fc_char_i(fcc), .stop_i(stop),
    .fc_ready_o(fifo_control), .cts_n_o(cts), .got0_o(g0), .got1_o(g1));
////////////////////////////////////////////////////////////////
task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
        n_mismatch++;
        $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
endtask
// request held until the rising edge that samples ack high; data taken there
task wb(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {26'h0, a}; dat <= {24'h0, d};
    do @(posedge clk); while (ack !== 1'b1);
    q = dato[7:0];
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
endtask
task settle;
    repeat (3) @(negedge clk);
endtask
task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
endtask
////////////////////////////////////////////////////////////////
task t_reset;
    wb(1'b0, `UEFC_OFS_FEAT, 8'h00); chk("feature", q, 8'h00);
    wb(1'b0, `UEFC_OFS_EFC, 8'h00); chk("enhanced", q, 8'h00);
    wb(1'b0, 6'h3C, 8'h00); chk("unmapped", q, 8'h00);
    settle;
    chk("rts idle", {7'h0, rts}, 8'h01);
    chk("dtr idle", {7'h0, dtr}, 8'h01);
endtask
task t_gate;
    wb(1'b1, `UEFC_OFS_IEN, 8'hFF); settle; chk("ien locked", ien, 8'h0F);
    wb(1'b1, `UEFC_OFS_FCTL, 8'hFF); settle; chk("fctl locked", fctl, 8'hCF);
    wb(1'b1, `UEFC_OFS_EFC, 8'h10);
    wb(1'b1, `UEFC_OFS_IEN, 8'hFF); settle; chk("ien open", ien, 8'hFF);
endtask
task t_ir;
    @(posedge clk); ir <= 1'b1;
    settle; chk("ir normal", {7'h0, irout}, 8'h01);
    wb(1'b1, `UEFC_OFS_FEAT, 8'h10); settle; chk("ir inverted", {7'h0, irout}, 8'h00);
endtask
// three pushes also fire three flow requests; flow selection is still off here
task t_level;
    repeat (3) begin
        @(posedge clk); push <= 1'b1;
        @(posedge clk); push <= 1'b0;
    end
    wb(1'b0, `UEFC_OFS_TXLVL, 8'h00); chk("tx level", q, 8'h03);
    wb(1'b1, `UEFC_OFS_TX_FIFO_TRIGGER, 8'h04); settle; chk("below trig", {7'h0, tti}, 8'h01);
    wb(1'b1, `UEFC_OFS_TX_FIFO_TRIGGER, 8'h03); settle; chk("at trig", {7'h0, tti}, 8'h00);
endtask
task t_flow;
    wb(1'b1, `UEFC_OFS_OFF1, 8'h13);
    wb(1'b1, `UEFC_OFS_OFF2, 8'h93);
    wb(1'b1, `UEFC_OFS_EFC, 8'h1C);
    @(posedge clk); push <= 1'b1;
    @(posedge clk); push <= 1'b0;
    repeat (12) @(negedge clk);
    chk("first pause", g0, 8'h13);
    chk("second pause", g1, 8'h93);
    chk("flow done", {7'h0, fcv}, 8'h00);
endtask
task t_cts;
    wb(1'b1, `UEFC_OFS_EFC, 8'h10);
    wb(1'b1, `UEFC_OFS_EFC, 8'h90);
    stop <= 1'b1; settle; chk("halt", {7'h0, halt}, 8'h01);
    @(posedge clk); stop <= 1'b0;
    settle; chk("resume", {7'h0, halt}, 8'h00);
endtask
// four bytes queued so far: drain them while the shifter still runs
task t_rs485;
    @(posedge clk); busy <= 1'b1;
    repeat (4) begin
        @(posedge clk); pop <= 1'b1;
        @(posedge clk); pop <= 1'b0;
    end
    settle; chk("int holding", {7'h0, txint}, 8'h01);
    wb(1'b1, `UEFC_OFS_DLY, 8'h20);
    wb(1'b1, `UEFC_OFS_FEAT, 8'h30);
    settle; chk("int shifter", {7'h0, txint}, 8'h00);
    chk("dir busy", {7'h0, rts}, 8'h01);
    @(posedge clk); busy <= 1'b0;
    settle; chk("dir hold", {7'h0, rts}, 8'h01);
    chk("int empty", {7'h0, txint}, 8'h01);
    repeat (2) begin
        @(posedge clk); tick <= 1'b1;
        @(posedge clk); tick <= 1'b0;
    end
    settle; chk("dir off", {7'h0, rts}, 8'h00);
    @(posedge clk); push <= 1'b1;
    @(posedge clk); push <= 1'b0;
    settle; chk("dir on load", {7'h0, rts}, 8'h01);
endtask
// the push pulse stands one cycle: looked at on the falling edge inside it
task rx_char(input logic [7:0] c, input logic [7:0] p);
    @(posedge clk); rxv <= 1'b1; rxc <= c;
    @(posedge clk); rxv <= 1'b0;
    @(negedge clk); chk("rx push", {7'h0, rxp}, p);
endtask
task t_rx;
    wb(1'b1, `UEFC_OFS_EFC, 8'h31);
    rx_char(8'h41, 8'h01); chk("rx data", rxd, 8'h41);
    rx_char(8'h93, 8'h00);
    wb(1'b0, `UEFC_OFS_RXLVL, 8'h00); chk("rx level", q, 8'h01);
    wb(1'b0, `UEFC_OFS_ISTS, 8'h00); chk("char flag", q, 8'h10);
    settle; chk("remote pause", {7'h0, halt}, 8'h01);
    chk("rx trig int", {7'h0, rti}, 8'h00);
    @(posedge clk); rxpop <= 1'b1;
    @(posedge clk); rxpop <= 1'b0;
    wb(1'b0, `UEFC_OFS_RXLVL, 8'h00); chk("rx drained", q, 8'h00);
endtask
////////////////////////////////////////////////////////////////
always @(posedge clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 5000) begin
        n_mismatch++;
        end_of_test;
    end
end
initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    t_reset;
    t_gate;
    t_ir;
    t_level;
    t_flow;
    t_cts;
    t_rs485;
    t_rx;
    end_of_test;
end
endmodule
`default_nettype wire
